// ===== tmc_pkg.sv
/*
  Shared constants and carrier types for the timer/counter pair with the
  external interrupt flags.
  Assumes a CPU core that reaches the registers over the special function
  register bus, one byte per address, all on the CPU clock.
*/
`default_nettype none

package tmc_pkg;

  // ---------------------------------------------------------------------
  // Register addresses on the special function register bus
  // ---------------------------------------------------------------------
  localparam logic [7:0] TMC_ADDR_CTRL    = 8'h88;
  localparam logic [7:0] TMC_ADDR_MODE    = 8'h89;
  localparam logic [7:0] TMC_ADDR_T0_LOW  = 8'h8a;
  localparam logic [7:0] TMC_ADDR_T1_LOW  = 8'h8b;
  localparam logic [7:0] TMC_ADDR_T0_HIGH = 8'h8c;
  localparam logic [7:0] TMC_ADDR_T1_HIGH = 8'h8d;
  localparam logic [7:0] TMC_ADDR_PRESC   = 8'h8e;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] TMC_RST_CTRL  = 8'h00;
  localparam logic [7:0] TMC_RST_MODE  = 8'h00;
  localparam logic [7:0] TMC_RST_COUNT = 8'h00;
  localparam logic [7:0] TMC_RST_PRESC = 8'h01;

  // ---------------------------------------------------------------------
  // Field positions of timer_control_flags
  // ---------------------------------------------------------------------
  localparam int TMC_CTRL_TF1 = 7;
  localparam int TMC_CTRL_TR1 = 6;
  localparam int TMC_CTRL_TF0 = 5;
  localparam int TMC_CTRL_TR0 = 4;
  localparam int TMC_CTRL_IE1 = 3;
  localparam int TMC_CTRL_IT1 = 2;
  localparam int TMC_CTRL_IE0 = 1;
  localparam int TMC_CTRL_IT0 = 0;

  // ---------------------------------------------------------------------
  // Field positions of timer_mode_select and clock_prescale_control
  // ---------------------------------------------------------------------
  localparam int TMC_MODE_GATE1   = 7;
  localparam int TMC_MODE_SRC1    = 6;
  localparam int TMC_MODE_M1_HIGH = 5;
  localparam int TMC_MODE_M1_LOW  = 4;
  localparam int TMC_MODE_GATE0   = 3;
  localparam int TMC_MODE_SRC0    = 2;
  localparam int TMC_MODE_M0_HIGH = 1;
  localparam int TMC_MODE_M0_LOW  = 0;
  localparam int TMC_PRESC_FAST1  = 4;
  localparam int TMC_PRESC_FAST0  = 3;

  // ---------------------------------------------------------------------
  // Mode field codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] TMC_MODE_13BIT  = 2'b00;
  localparam logic [1:0] TMC_MODE_16BIT  = 2'b01;
  localparam logic [1:0] TMC_MODE_RELOAD = 2'b10;
  localparam logic [1:0] TMC_MODE_SPLIT  = 2'b11;

  // ---------------------------------------------------------------------
  // Slow divider length in CPU clocks per increment, and the divider phase that ends each fast tick
  // ---------------------------------------------------------------------
  localparam logic [3:0] TMC_DIV_SLOW = 4'hc;
  localparam logic [1:0] TMC_DIV_FAST_LAST = 2'h3;

  // ---------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tmc_sfr_req_t;

  typedef struct packed {
    logic tmr0;
    logic tmr1;
    logic ext0;
    logic ext1;
  } tmc_vec_ack_t;

endpackage

`default_nettype wire

// ===== tmc_pin_sync.sv
/*
  Three-stage pin synchroniser with a filtered level and a falling-edge pulse.
  Assumes the pin is asynchronous to clk_sys and idles high.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      fall_pulse
);

  logic sync_a_reg;
  logic sync_b_reg;
  logic sync_c_reg;

  // ---------------------------------------------------------------------
  // Capture chain; only the second stage reads the first
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_reg <= 1'b1;
      sync_b_reg <= 1'b1;
      sync_c_reg <= 1'b1;
    end else begin
      sync_a_reg <= pin_in;
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
    end
  end

  // ---------------------------------------------------------------------
  // Accept a change once stages two and three agree
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_out  <= 1'b1;
      fall_pulse <= 1'b0;
    end else begin
      fall_pulse <= (sync_b_reg == sync_c_reg) && !sync_c_reg && level_out;
      if (sync_b_reg == sync_c_reg) begin
        level_out <= sync_c_reg;
      end
    end
  end

endmodule

`default_nettype wire

// ===== tmc_timer01.sv
/*
  Timer/counter 0 and 1 with their control, mode and prescale registers and
  the two external interrupt flags.
  Assumes the CPU core drives one register request per cycle on the special
  function register bus and pulses a vector acknowledge when it enters a
  service routine. Pins arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_timer01
  import tmc_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire tmc_sfr_req_t sfr_req,
  output logic [7:0]        sfr_rdata,
  input  wire tmc_vec_ack_t vec_ack,
  input  wire logic         ext_int0_pin,
  input  wire logic         ext_int1_pin,
  input  wire logic         count_input_0,
  input  wire logic         count_input_1,
  output logic [7:0]        timer_control_flags,
  output logic              timer0_overflow_pulse,
  output logic              timer1_overflow_pulse
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic [7:0]  ctrl_next;
  logic [7:0]  mode_reg;
  logic [7:0]  presc_reg;
  logic [7:0]  t0_low_reg;
  logic [7:0]  t0_high_reg;
  logic [7:0]  t1_low_reg;
  logic [7:0]  t1_high_reg;
  logic [3:0]  div_cnt_reg;
  logic [3:0]  pins_raw;
  logic [3:0]  pin_level;
  logic [3:0]  pin_fall;
  logic        tick_slow;
  logic        tick_fast;
  logic        tick0_clk;
  logic        tick0;
  logic        tick1;
  logic        split0;
  logic        run0;
  logic        run1;
  logic        inc0;
  logic        inc0_high;
  logic        inc1;
  logic [16:0] adv0;
  logic [16:0] adv1;
  logic        ovf0_evt;
  logic        ovf1_evt;
  logic        wr_ctrl;
  logic        wr_t0_low;
  logic        wr_t0_high;
  logic        wr_t1_low;
  logic        wr_t1_high;

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  // Count pins are the port alternate functions wired in by the port block
  assign pins_raw = {count_input_1, count_input_0, ext_int1_pin, ext_int0_pin};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      tmc_pin_sync u_sync (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .pin_in     (pins_raw[i]),
        .level_out  (pin_level[i]),
        .fall_pulse (pin_fall[i])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Prescaler: /12 and /4 ticks from one counter
  // ---------------------------------------------------------------------
  // One shared divider keeps /4 and /12 ticks phase aligned
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 4'h0;
    end else if (div_cnt_reg == TMC_DIV_SLOW - 4'h1) begin
      div_cnt_reg <= 4'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
    end
  end

  assign tick_slow = (div_cnt_reg == TMC_DIV_SLOW - 4'h1);
  assign tick_fast = (div_cnt_reg[1:0] == TMC_DIV_FAST_LAST);

  // ---------------------------------------------------------------------
  // Count enables
  // ---------------------------------------------------------------------
  assign split0    = (mode_reg[TMC_MODE_M0_HIGH:TMC_MODE_M0_LOW] == TMC_MODE_SPLIT);
  assign tick0_clk = presc_reg[TMC_PRESC_FAST0] ? tick_fast : tick_slow;
  // Pin source counts synchronised falling edges; prescale ignored
  assign tick0     = mode_reg[TMC_MODE_SRC0] ? pin_fall[2] : tick0_clk;
  assign tick1     = mode_reg[TMC_MODE_SRC1] ? pin_fall[3]
                   : (presc_reg[TMC_PRESC_FAST1] ? tick_fast : tick_slow);
  assign run0      = timer_control_flags[TMC_CTRL_TR0]
                   & (!mode_reg[TMC_MODE_GATE0] | pin_level[0]);
  // With timer 0 split, timer 1 runs on its mode alone, as its run bit is lent out
  assign run1      = (split0 | timer_control_flags[TMC_CTRL_TR1])
                   & (!mode_reg[TMC_MODE_GATE1] | pin_level[1]);
  assign inc0      = run0 & tick0;
  // Split high byte: clock ticks only, timer 1 run bit
  assign inc0_high = split0 & timer_control_flags[TMC_CTRL_TR1] & tick0_clk;
  // Timer 1 in split mode holds its count
  assign inc1      = run1 & tick1
                   & (mode_reg[TMC_MODE_M1_HIGH:TMC_MODE_M1_LOW] != TMC_MODE_SPLIT);

  // ---------------------------------------------------------------------
  // Counter step: returns {overflow, high, low}
  // ---------------------------------------------------------------------
  function automatic logic [16:0] tmc_advance(input logic [1:0] mode,
                                              input logic [7:0] low,
                                              input logic [7:0] high);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [16:0] res;
    c13 = {high, low[4:0]} + 13'h1;
    c16 = {high, low} + 16'h1;
    case (mode)
      TMC_MODE_13BIT: begin
        // Top three low-byte bits are left untouched and read back as stored
        res = {({high, low[4:0]} == 13'h1fff), c13[12:5], low[7:5], c13[4:0]};
      end
      TMC_MODE_16BIT: begin
        res = {({high, low} == 16'hffff), c16};
      end
      TMC_MODE_RELOAD: begin
        res = {(low == 8'hff), high, (low == 8'hff) ? high : low + 8'h1};
      end
      default: begin
        res = {(low == 8'hff), high, low + 8'h1};
      end
    endcase
    return res;
  endfunction

  assign adv0 = tmc_advance(mode_reg[TMC_MODE_M0_HIGH:TMC_MODE_M0_LOW], t0_low_reg, t0_high_reg);
  assign adv1 = tmc_advance(mode_reg[TMC_MODE_M1_HIGH:TMC_MODE_M1_LOW], t1_low_reg, t1_high_reg);

  // Overflow events in the cycle the count rolls or reloads
  assign ovf0_evt = inc0 & adv0[16];
  assign ovf1_evt = (inc1 & adv1[16]) | (inc0_high & (t0_high_reg == 8'hff));

  // ---------------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------------
  assign wr_ctrl    = sfr_req.wr && (sfr_req.addr == TMC_ADDR_CTRL);
  assign wr_t0_low  = sfr_req.wr && (sfr_req.addr == TMC_ADDR_T0_LOW);
  assign wr_t0_high = sfr_req.wr && (sfr_req.addr == TMC_ADDR_T0_HIGH);
  assign wr_t1_low  = sfr_req.wr && (sfr_req.addr == TMC_ADDR_T1_LOW);
  assign wr_t1_high = sfr_req.wr && (sfr_req.addr == TMC_ADDR_T1_HIGH);

  // ---------------------------------------------------------------------
  // Mode and prescale registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= TMC_RST_MODE;
    end else if (sfr_req.wr && (sfr_req.addr == TMC_ADDR_MODE)) begin
      mode_reg <= sfr_req.wdata;
    end
  end

  // Low three bits belong to the memory interface; kept for read back
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= TMC_RST_PRESC;
    end else if (sfr_req.wr && (sfr_req.addr == TMC_ADDR_PRESC)) begin
      presc_reg <= sfr_req.wdata & 8'h3f;
    end
  end

  // ---------------------------------------------------------------------
  // Timer 0 count bytes; a software write beats the count in that cycle
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      t0_low_reg <= TMC_RST_COUNT;
    end else if (wr_t0_low) begin
      t0_low_reg <= sfr_req.wdata;
    end else if (inc0) begin
      t0_low_reg <= adv0[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      t0_high_reg <= TMC_RST_COUNT;
    end else if (wr_t0_high) begin
      t0_high_reg <= sfr_req.wdata;
    end else if (inc0_high) begin
      t0_high_reg <= t0_high_reg + 8'h1;
    end else if (inc0 && !split0) begin
      t0_high_reg <= adv0[15:8];
    end
  end

  // ---------------------------------------------------------------------
  // Timer 1 count bytes
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      t1_low_reg <= TMC_RST_COUNT;
    end else if (wr_t1_low) begin
      t1_low_reg <= sfr_req.wdata;
    end else if (inc1) begin
      t1_low_reg <= adv1[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      t1_high_reg <= TMC_RST_COUNT;
    end else if (wr_t1_high) begin
      t1_high_reg <= sfr_req.wdata;
    end else if (inc1) begin
      t1_high_reg <= adv1[15:8];
    end
  end

  // ---------------------------------------------------------------------
  // Control flags: write, then clears, then hardware sets (sets win)
  // ---------------------------------------------------------------------
  always_comb begin
    ctrl_next = timer_control_flags;
    if (wr_ctrl) begin
      ctrl_next[TMC_CTRL_TR1] = sfr_req.wdata[TMC_CTRL_TR1];
      ctrl_next[TMC_CTRL_TR0] = sfr_req.wdata[TMC_CTRL_TR0];
      ctrl_next[TMC_CTRL_TF1] = sfr_req.wdata[TMC_CTRL_TF1];
      ctrl_next[TMC_CTRL_TF0] = sfr_req.wdata[TMC_CTRL_TF0];
      ctrl_next[TMC_CTRL_IT1] = sfr_req.wdata[TMC_CTRL_IT1];
      ctrl_next[TMC_CTRL_IT0] = sfr_req.wdata[TMC_CTRL_IT0];
      // Interrupt flags are writable only while already in edge mode
      if (timer_control_flags[TMC_CTRL_IT1]) begin
        ctrl_next[TMC_CTRL_IE1] = sfr_req.wdata[TMC_CTRL_IE1];
      end
      if (timer_control_flags[TMC_CTRL_IT0]) begin
        ctrl_next[TMC_CTRL_IE0] = sfr_req.wdata[TMC_CTRL_IE0];
      end
    end
    if (vec_ack.tmr1) begin
      ctrl_next[TMC_CTRL_TF1] = 1'b0;
    end
    if (vec_ack.tmr0) begin
      ctrl_next[TMC_CTRL_TF0] = 1'b0;
    end
    if (vec_ack.ext1 && timer_control_flags[TMC_CTRL_IT1]) begin
      ctrl_next[TMC_CTRL_IE1] = 1'b0;
    end
    if (vec_ack.ext0 && timer_control_flags[TMC_CTRL_IT0]) begin
      ctrl_next[TMC_CTRL_IE0] = 1'b0;
    end
    if (ovf1_evt) begin
      ctrl_next[TMC_CTRL_TF1] = 1'b1;
    end
    if (ovf0_evt) begin
      ctrl_next[TMC_CTRL_TF0] = 1'b1;
    end
    // Level mode: flag tracks the pin and overrides any write
    if (timer_control_flags[TMC_CTRL_IT1]) begin
      if (pin_fall[1]) begin
        ctrl_next[TMC_CTRL_IE1] = 1'b1;
      end
    end else begin
      ctrl_next[TMC_CTRL_IE1] = !pin_level[1];
    end
    if (timer_control_flags[TMC_CTRL_IT0]) begin
      if (pin_fall[0]) begin
        ctrl_next[TMC_CTRL_IE0] = 1'b1;
      end
    end else begin
      ctrl_next[TMC_CTRL_IE0] = !pin_level[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_flags <= TMC_RST_CTRL;
    end else begin
      timer_control_flags <= ctrl_next;
    end
  end

  // ---------------------------------------------------------------------
  // Overflow pulses, one clock each
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer0_overflow_pulse <= 1'b0;
      timer1_overflow_pulse <= 1'b0;
    end else begin
      timer0_overflow_pulse <= ovf0_evt;
      timer1_overflow_pulse <= ovf1_evt;
    end
  end

  // ---------------------------------------------------------------------
  // Read data, one cycle after the strobe; unmapped reads return zero
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        TMC_ADDR_CTRL:    sfr_rdata <= timer_control_flags;
        TMC_ADDR_MODE:    sfr_rdata <= mode_reg;
        TMC_ADDR_T0_LOW:  sfr_rdata <= t0_low_reg;
        TMC_ADDR_T0_HIGH: sfr_rdata <= t0_high_reg;
        TMC_ADDR_T1_LOW:  sfr_rdata <= t1_low_reg;
        TMC_ADDR_T1_HIGH: sfr_rdata <= t1_high_reg;
        TMC_ADDR_PRESC:   sfr_rdata <= presc_reg;
        default:          sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== tmc_timer01_assertions.sv
/*
  Concurrent checks on the ports of the timer/counter block.
  Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_timer01_assertions
  import tmc_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         rst_n,
  input wire tmc_sfr_req_t sfr_req,
  input wire logic [7:0]   sfr_rdata,
  input wire tmc_vec_ack_t vec_ack,
  input wire logic         ext_int0_pin,
  input wire logic         ext_int1_pin,
  input wire logic         count_input_0,
  input wire logic         count_input_1,
  input wire logic [7:0]   timer_control_flags,
  input wire logic         timer0_overflow_pulse,
  input wire logic         timer1_overflow_pulse
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // A control write competes with hardware set and clear
  wire logic ctl_wr = sfr_req.wr && (sfr_req.addr == TMC_ADDR_CTRL);

  // Flag and pulse update on the same edge; a set beats any clear there
  a_pulse_after_tf0: assert property (timer0_overflow_pulse |-> timer_control_flags[5])
    else $error("timer 0 pulse without flag");
  a_pulse_after_tf1: assert property (timer1_overflow_pulse |-> timer_control_flags[7])
    else $error("timer 1 pulse without flag");
  a_pulse_one_cycle: assert property (timer0_overflow_pulse |=> !timer0_overflow_pulse)
    else $error("timer 0 pulse longer than one cycle");
  a_ctrl_bits_write: assert property (ctl_wr |=> timer_control_flags[6] == $past(sfr_req.wdata[6])
    && timer_control_flags[4] == $past(sfr_req.wdata[4])
    && timer_control_flags[2] == $past(sfr_req.wdata[2])
    && timer_control_flags[0] == $past(sfr_req.wdata[0]))
    else $error("run or type bit not written");
  a_level_ie0_low: assert property ((!timer_control_flags[0] && !ext_int0_pin)[*8]
    |-> timer_control_flags[1]) else $error("level flag 0 not set");
  a_level_ie1_high: assert property ((!timer_control_flags[2] && ext_int1_pin)[*8]
    |-> !timer_control_flags[3]) else $error("level flag 1 not clear");
  a_edge_ie0_hold: assert property (timer_control_flags[0] && timer_control_flags[1]
    && !vec_ack.ext0 && !ctl_wr |=> timer_control_flags[1]) else $error("edge flag lost");
  a_vec_clear_tf0: assert property (vec_ack.tmr0 && !ctl_wr
    |=> !timer_control_flags[5] || timer0_overflow_pulse) else $error("flag 0 not cleared");
  a_read_ctrl_value: assert property (sfr_req.rd && sfr_req.addr == TMC_ADDR_CTRL
    |=> sfr_rdata == $past(timer_control_flags)) else $error("control read wrong");
  a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
endmodule

bind tmc_timer01 tmc_timer01_assertions chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .vec_ack(vec_ack), .ext_int0_pin(ext_int0_pin), .ext_int1_pin(ext_int1_pin),
  .count_input_0(count_input_0), .count_input_1(count_input_1),
  .timer_control_flags(timer_control_flags),
  .timer0_overflow_pulse(timer0_overflow_pulse),
  .timer1_overflow_pulse(timer1_overflow_pulse));

`default_nettype wire

// ===== tmc_cpu_model.sv
/*
  CPU core stand-in: register writes, reads and vector acknowledges.
  Assumes the bench calls its tasks; drives at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_cpu_model
  import tmc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] sfr_rdata,
  output var tmc_sfr_req_t sfr_req,
  output var tmc_vec_ack_t vec_ack
);
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  initial begin
    sfr_req = '0;
    vec_ack = '0;
  end

  // Idle lines carry the inverse, so no stale address looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_sys);
    sfr_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask

  // Read data is registered, so it is taken one cycle on
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_sys);
    d = sfr_rdata;
    sfr_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
  endtask

  // One-cycle entry into a service routine
  task automatic ack(input tmc_vec_ack_t v);
    @(negedge clk_sys);
    vec_ack = v;
    @(negedge clk_sys);
    vec_ack = '0;
  endtask
endmodule

`default_nettype wire

// ===== tb_top.sv
/*
  Self-checking bench for the timer/counter block.
  Assumes the CPU model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import tmc_pkg::*;
  // ---------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------
  logic         clk_sys = 1'b0;
  logic         rst_n = 1'b0;
  logic [3:0]   pin_v = 4'hf; // int0, int1, count0, count1; idle high
  logic [7:0]   sfr_rdata;
  logic [7:0]   rv;
  logic         p0;
  logic         p1;
  tmc_sfr_req_t sfr_req;
  tmc_vec_ack_t vec_ack;
  int           fail_count = 0;
  int           checks = 0;
  integer       seed = 32'hdc42;
  int           n;

  always #5 clk_sys = ~clk_sys;

  tmc_cpu_model cpu_u (.clk_sys(clk_sys), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req),
    .vec_ack(vec_ack));
  tmc_timer01 dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .vec_ack(vec_ack), .ext_int0_pin(pin_v[0]),
    .ext_int1_pin(pin_v[1]), .count_input_0(pin_v[2]), .count_input_1(pin_v[3]),
    .timer_control_flags(), .timer0_overflow_pulse(p0), .timer1_overflow_pulse(p1));

  // Prescale bits 7:6 always read zero
  function automatic logic [7:0] presc_exp(input logic [7:0] w);
    return {2'b00, w[5:0]};
  endfunction

  // Counting leaves the top three bits of a 13-bit low byte alone
  function automatic logic [7:0] low13_exp(input logic [7:0] w);
    return {w[7:5], 5'h00};
  endfunction

  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] e);
    checks++;
    if (seen !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", w, e, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string w);
    logic [7:0] v;
    cpu_u.rd(a, v);
    check(w, v, e);
  endtask

  // Bounded wait for an overflow pulse; a miss ends the run
  task automatic wait_ovf(input bit t1, input int lim);
    int k;
    k = 0;
    while ((t1 ? p1 : p0) !== 1'b1) begin
      @(negedge clk_sys);
      k++;
      if (k == lim) begin
        check("overflow wait", 8'h00, 8'h01);
        stop_test();
      end
    end
  endtask

  // Falling then rising edge on the masked pins
  task automatic blip(input logic [3:0] m);
    pin_v = pin_v & ~m;
    repeat (6) @(negedge clk_sys);
    pin_v = pin_v | m;
    repeat (6) @(negedge clk_sys);
  endtask

  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    for (int a = 8'h88; a <= 8'h8e; a++) rchk(8'(a), (a == 8'h8e) ? TMC_RST_PRESC : 8'h00, "reset");
    rchk(8'h80, 8'h00, "unmapped");
    repeat (4) begin
      // Both sources on idle pins, so a split timer 0 cannot run timer 1
      rv = 8'($random(seed)) | 8'h44;
      cpu_u.wr(TMC_ADDR_MODE, rv);
      rchk(TMC_ADDR_MODE, rv, "mode");
      cpu_u.wr(TMC_ADDR_PRESC, rv);
      rchk(TMC_ADDR_PRESC, presc_exp(rv), "prescale");
      for (int a = 8'h8a; a <= 8'h8d; a++) begin
        cpu_u.wr(8'(a), rv ^ 8'(a));
        rchk(8'(a), rv ^ 8'(a), "count byte");
      end
    end
    $display("registers done");
    cpu_u.wr(TMC_ADDR_PRESC, 8'h08);
    cpu_u.wr(TMC_ADDR_MODE, 8'h01);
    cpu_u.wr(TMC_ADDR_T0_HIGH, 8'hff);
    cpu_u.wr(TMC_ADDR_T0_LOW, 8'hf0);
    cpu_u.wr(TMC_ADDR_CTRL, 8'h10);
    wait_ovf(1'b0, 100);
    rchk(TMC_ADDR_CTRL, 8'h30, "tf0 set");
    rchk(TMC_ADDR_T0_HIGH, 8'h00, "t0 rolled");
    cpu_u.wr(TMC_ADDR_CTRL, 8'h00);
    cpu_u.wr(TMC_ADDR_PRESC, 8'h01);
    cpu_u.wr(TMC_ADDR_MODE, 8'h00);
    cpu_u.wr(TMC_ADDR_T1_HIGH, 8'hff);
    cpu_u.wr(TMC_ADDR_T1_LOW, 8'hfe);
    cpu_u.wr(TMC_ADDR_CTRL, 8'h40);
    wait_ovf(1'b1, 40);
    rchk(TMC_ADDR_CTRL, 8'hc0, "tf1 set");
    cpu_u.wr(TMC_ADDR_CTRL, 8'h00);
    rchk(TMC_ADDR_T1_LOW, low13_exp(8'hfe), "t1 low 13-bit");
    rchk(TMC_ADDR_T1_HIGH, 8'h00, "t1 high 13-bit");
    $display("overflow done");
    rv = 8'($random(seed));
    cpu_u.wr(TMC_ADDR_MODE, 8'h02);
    cpu_u.wr(TMC_ADDR_T0_HIGH, rv);
    cpu_u.wr(TMC_ADDR_T0_LOW, 8'hff);
    cpu_u.wr(TMC_ADDR_CTRL, 8'h10);
    wait_ovf(1'b0, 40);
    cpu_u.ack(tmc_vec_ack_t'(4'b1000));
    rchk(TMC_ADDR_CTRL, 8'h10, "tf0 vector clear");
    cpu_u.wr(TMC_ADDR_CTRL, 8'h00);
    rchk(TMC_ADDR_T0_LOW, rv, "reload value");
    $display("reload done");
    cpu_u.wr(TMC_ADDR_T0_LOW, 8'h00);
    cpu_u.wr(TMC_ADDR_MODE, 8'h09);
    cpu_u.wr(TMC_ADDR_PRESC, 8'h08);
    pin_v[0] = 1'b0;
    cpu_u.wr(TMC_ADDR_CTRL, 8'h10);
    repeat (40) @(negedge clk_sys);
    rchk(TMC_ADDR_T0_LOW, 8'h00, "gate closed");
    rchk(TMC_ADDR_CTRL, 8'h12, "level flag 0");
    cpu_u.wr(TMC_ADDR_CTRL, 8'h10);
    rchk(TMC_ADDR_CTRL, 8'h12, "level write ignored");
    pin_v[0] = 1'b1;
    repeat (40) @(negedge clk_sys);
    cpu_u.wr(TMC_ADDR_CTRL, 8'h00);
    cpu_u.rd(TMC_ADDR_T0_LOW, rv);
    check("gate open", {7'h00, rv != 8'h00}, 8'h01);
    $display("gate done");
    for (int a = 8'h8a; a <= 8'h8d; a++) cpu_u.wr(8'(a), 8'h00);
    cpu_u.wr(TMC_ADDR_MODE, 8'h55);
    cpu_u.wr(TMC_ADDR_CTRL, 8'h50);
    n = 1 + ($unsigned($random(seed)) % 16);
    repeat (n) blip(4'b1100);
    cpu_u.wr(TMC_ADDR_CTRL, 8'h00);
    rchk(TMC_ADDR_T0_LOW, 8'(n), "pin count 0");
    rchk(TMC_ADDR_T1_LOW, 8'(n), "pin count 1");
    $display("counter done");
    cpu_u.wr(TMC_ADDR_CTRL, 8'h05);
    blip(4'b0011);
    rchk(TMC_ADDR_CTRL, 8'h0f, "edge flags");
    cpu_u.ack(tmc_vec_ack_t'(4'b0010));
    rchk(TMC_ADDR_CTRL, 8'h0d, "edge vector clear");
    cpu_u.wr(TMC_ADDR_CTRL, 8'h05);
    rchk(TMC_ADDR_CTRL, 8'h05, "edge soft clear");
    cpu_u.wr(TMC_ADDR_CTRL, 8'h00);
    pin_v[1] = 1'b0;
    repeat (8) @(negedge clk_sys);
    rchk(TMC_ADDR_CTRL, 8'h08, "level flag 1 set");
    pin_v[1] = 1'b1;
    repeat (8) @(negedge clk_sys);
    rchk(TMC_ADDR_CTRL, 8'h00, "level flag 1 clear");
    $display("interrupts done");
    stop_test();
  end
endmodule

`default_nettype wire
